// ==== src/ee_pkg.sv ====
// Shared constants and types for the two-wire page-write memory slave.
package ee_pkg;

  // ==========================================================================
  // Addressing and framing
  // ==========================================================================
  // Fixed four-bit device code carried in the top of the control byte.
  localparam logic [3:0] DEV_CODE = 4'ha;
  // Width of the word address for the 128-byte array.
  localparam int ADDR_W = 7;
  // Width of the in-page offset for the 16-byte page.
  localparam int PAGE_W = 4;
  // Bit count after the eighth data bit of a byte.
  localparam logic [3:0] BIT_LAST = 4'h8;
  // Bit count after the acknowledge clock of a byte.
  localparam logic [3:0] BIT_ACK = 4'h9;
  // Word address bit that selects the upper, protectable half.
  localparam int PROT_BIT = 6;
  // Address pointer value after reset.
  localparam logic [6:0] PTR_RST = 7'h00;

  // ==========================================================================
  // Write cycle timing
  // ==========================================================================
  // Self-timed write cycle length in microseconds.
  localparam int WRITE_TIME_US = 5;
  // Device clock rate in MHz.
  localparam int CLK_MHZ = 125;
  // Write cycle length in device clocks.
  localparam int WRITE_CYCLES_DEF = WRITE_TIME_US * CLK_MHZ;
  // Last step of the page buffer copy, two clocks per entry.
  localparam logic [4:0] COPY_LAST = 5'h1f;

  // ==========================================================================
  // Bus state machine
  // ==========================================================================
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_CTRL  = 6'h02,
    ST_ADDR  = 6'h04,
    ST_WDATA = 6'h08,
    ST_RDATA = 6'h10,
    ST_WAIT  = 6'h20
  } ee_state_t;

endpackage : ee_pkg

// ==== src/ee_mem_if.sv ====
// Port bundle between the controller and one byte-wide memory.
interface ee_mem_if #(
  parameter int AW = 7
);
  // Write strobe, address and data.
  logic we;
  logic [AW-1:0] waddr;
  logic [7:0] wdata;
  // Read address and registered read data.
  logic [AW-1:0] raddr;
  logic [7:0] rdata;

  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : ee_mem_if

// ==== src/ee_mem.sv ====
// Byte-wide memory with one write port and a registered read port.
module ee_mem #(
  parameter int AW = 7
) (
  // Clock.
  input wire logic clk,
  // Access port.
  ee_mem_if.mem bus
);

  // ==========================================================================
  // Storage
  // ==========================================================================
  // Array contents carry no reset, as in a real storage block.
  logic [7:0] store_reg [2**AW];

  // Write on the strobe and always present the addressed byte one clock later.
  always_ff @(posedge clk) begin
    if (bus.we) begin
      store_reg[bus.waddr] <= bus.wdata;
    end
    bus.rdata <= store_reg[bus.raddr];
  end

endmodule : ee_mem

// ==== src/ee_page_eeprom.sv ====
// Two-wire slave of a 128-byte memory with page buffer and write protect.
// ============================================================================
module ee_page_eeprom #(
  // Write cycle length in clocks; must be at least 32 so the copy completes.
  parameter int unsigned WRITE_CYCLES = ee_pkg::WRITE_CYCLES_DEF
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Two-wire bus; the data pin is open drain.
  input wire logic scl_pin,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Strap pins.
  input wire logic chip_select_bit0,
  input wire logic chip_select_bit1,
  input wire logic chip_select_bit2,
  input wire logic write_protect_pin,
  // Status.
  output logic write_busy
);

  // ==========================================================================
  // Declarations
  // Synchroniser stages; the third stages exist only for edge detection.
  logic scl_s1_reg, scl_s2_reg, scl_s3_reg;
  logic sda_s1_reg, sda_s2_reg, sda_s3_reg;
  logic [3:0] pins_s1_reg, pins_s2_reg;
  // Bus events seen on the synchronised lines.
  logic scl_rise, scl_fall, bus_start, bus_stop;
  // Bit counter, receive shifter and the acknowledge seen from the master.
  logic [3:0] cnt_reg;
  logic [7:0] rx_reg;
  logic mack_reg;
  // Transmit shifter.
  logic [7:0] tx_reg;
  // Protocol state.
  ee_pkg::ee_state_t state_reg;
  // Shared address pointer.
  logic [6:0] ptr_reg;
  // Page buffer bookkeeping.
  logic [15:0] valid_reg;
  logic got_data_reg;
  // Write cycle control.
  logic busy_reg;
  logic copy_on_reg;
  logic [4:0] cstep_reg;
  logic [31:0] wc_cnt_reg;
  logic [2:0] page_reg;
  logic wp_lat_reg;
  // Decoded byte boundary events.
  logic byte_done, ack_done, ctrl_match, ack_now, prot_hit;
  // Memory ports.
  ee_mem_if #(.AW(ee_pkg::ADDR_W)) arr_if ();
  ee_mem_if #(.AW(ee_pkg::PAGE_W)) pbuf_if ();

  // ==========================================================================
  // Input synchronisers
  // Every pin passes two flops; the lines rest high, as with pull-ups.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_s3_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_s3_reg <= 1'b1;
      pins_s1_reg <= 4'h0;
      pins_s2_reg <= 4'h0;
    end else begin
      scl_s1_reg <= scl_pin;
      scl_s2_reg <= scl_s1_reg;
      scl_s3_reg <= scl_s2_reg;
      sda_s1_reg <= sda_in;
      sda_s2_reg <= sda_s1_reg;
      sda_s3_reg <= sda_s2_reg;
      pins_s1_reg <= {write_protect_pin, chip_select_bit2, chip_select_bit1, chip_select_bit0};
      pins_s2_reg <= pins_s1_reg;
    end
  end

  // Edges of the clock line, and data edges while the clock line is high.
  always_comb begin
    scl_rise = scl_s2_reg & ~scl_s3_reg;
    scl_fall = ~scl_s2_reg & scl_s3_reg;
    bus_start = scl_s2_reg & scl_s3_reg & sda_s3_reg & ~sda_s2_reg;
    bus_stop = scl_s2_reg & scl_s3_reg & ~sda_s3_reg & sda_s2_reg;
  end
  // Byte boundaries and the acknowledge decision.
  always_comb begin
    byte_done = scl_fall && (cnt_reg == ee_pkg::BIT_LAST);
    ack_done = scl_fall && (cnt_reg == ee_pkg::BIT_ACK);
    // A busy device stays silent so the master can poll for completion.
    ctrl_match = (rx_reg[7:4] == ee_pkg::DEV_CODE) && (rx_reg[3:1] == pins_s2_reg[2:0])
                 && !busy_reg;
    ack_now = 1'b0;
    unique case (state_reg)
      ee_pkg::ST_CTRL: ack_now = ctrl_match;
      ee_pkg::ST_ADDR: ack_now = 1'b1;
      ee_pkg::ST_WDATA: ack_now = 1'b1;
      ee_pkg::ST_IDLE, ee_pkg::ST_RDATA, ee_pkg::ST_WAIT: ack_now = 1'b0;
    endcase
    // Upper half is guarded only while the protect level was high.
    prot_hit = wp_lat_reg && page_reg[ee_pkg::PROT_BIT - 4];
  end

  // ==========================================================================
  // Bit counter and receive shifter
  // Data is sampled on the rising clock; the ninth rise samples the master's ack.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_reg <= 4'h0;
      rx_reg <= 8'h00;
      mack_reg <= 1'b0;
    end else if (bus_start || bus_stop) begin
      cnt_reg <= 4'h0;
    end else if (scl_rise) begin
      if (cnt_reg < ee_pkg::BIT_LAST) begin
        rx_reg <= {rx_reg[6:0], sda_s2_reg};
        cnt_reg <= cnt_reg + 4'h1;
      end else if (cnt_reg == ee_pkg::BIT_LAST) begin
        cnt_reg <= ee_pkg::BIT_ACK;
        mack_reg <= ~sda_s2_reg;
      end
    end else if (byte_done) begin
      // The ninth rise overwrites this preset; it samples the slave's own control ack, which lets the first read byte load.
      mack_reg <= 1'b1;
    end else if (ack_done) begin
      cnt_reg <= 4'h0;
    end
  end

  // ==========================================================================
  // Protocol state
  // A repeated Start simply restarts at the control byte, abandoning the write.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= ee_pkg::ST_IDLE;
    end else if (bus_start) begin
      state_reg <= ee_pkg::ST_CTRL;
    end else if (bus_stop) begin
      state_reg <= ee_pkg::ST_IDLE;
    end else if (byte_done) begin
      unique case (state_reg)
        ee_pkg::ST_CTRL: begin
          if (!ctrl_match) begin
            state_reg <= ee_pkg::ST_WAIT;
          end else if (rx_reg[0]) begin
            state_reg <= ee_pkg::ST_RDATA;
          end else begin
            state_reg <= ee_pkg::ST_ADDR;
          end
        end
        ee_pkg::ST_ADDR: state_reg <= ee_pkg::ST_WDATA;
        ee_pkg::ST_IDLE, ee_pkg::ST_WDATA, ee_pkg::ST_RDATA, ee_pkg::ST_WAIT: begin
          state_reg <= state_reg;
        end
      endcase
    end else if (ack_done && state_reg == ee_pkg::ST_RDATA && !mack_reg) begin
      // No ack from the master: stay off the bus until Stop or Start.
      state_reg <= ee_pkg::ST_WAIT;
    end
  end

  // ==========================================================================
  // Data line driver
  // Changes happen on the falling clock, except the release at Start or Stop, keeping data stable while high.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sda_oe <= 1'b0;
      tx_reg <= 8'h00;
    end else if (bus_start || bus_stop) begin
      sda_oe <= 1'b0;
    end else if (byte_done) begin
      sda_oe <= ack_now;
    end else if (ack_done) begin
      if (state_reg == ee_pkg::ST_RDATA && mack_reg) begin
        tx_reg <= arr_if.rdata;
        sda_oe <= ~arr_if.rdata[7];
      end else begin
        sda_oe <= 1'b0;
      end
    end else if (scl_fall && state_reg == ee_pkg::ST_RDATA && cnt_reg != 4'h0) begin
      tx_reg <= {tx_reg[6:0], 1'b0};
      sda_oe <= ~tx_reg[6];
    end
  end

  // The pin is only ever pulled low; the bus pull-up makes the ones.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sda_out <= 1'b0;
      write_busy <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      write_busy <= busy_reg;
    end
  end

  // ==========================================================================
  // Address pointer
  // Writes step within the page; reads step over the whole array.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ptr_reg <= ee_pkg::PTR_RST;
    end else if (byte_done && state_reg == ee_pkg::ST_ADDR) begin
      ptr_reg <= rx_reg[6:0];
    end else if (byte_done && state_reg == ee_pkg::ST_WDATA) begin
      ptr_reg <= {ptr_reg[6:4], ptr_reg[3:0] + 4'h1};
    end else if (ack_done && state_reg == ee_pkg::ST_RDATA && mack_reg) begin
      // A 7-bit add wraps from the top byte to zero by itself.
      ptr_reg <= ptr_reg + 7'h01;
    end
  end

  // ==========================================================================
  // Page buffer
  // Only marked entries are copied, so a short write leaves the page intact.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      valid_reg <= 16'h0000;
      got_data_reg <= 1'b0;
    end else if (byte_done && state_reg == ee_pkg::ST_ADDR) begin
      valid_reg <= 16'h0000;
      got_data_reg <= 1'b0;
    end else if (byte_done && state_reg == ee_pkg::ST_WDATA) begin
      // A seventeenth byte lands on the first entry again, oldest first.
      valid_reg[ptr_reg[3:0]] <= 1'b1;
      got_data_reg <= 1'b1;
    end
  end

  always_comb begin
    pbuf_if.we = byte_done && (state_reg == ee_pkg::ST_WDATA);
    pbuf_if.waddr = ptr_reg[3:0];
    pbuf_if.wdata = rx_reg;
    pbuf_if.raddr = cstep_reg[4:1];
  end

  // ==========================================================================
  // Self-timed write cycle
  // The copy takes two clocks per entry; the cycle always runs its full length,
  // even when protection suppressed every store.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      busy_reg <= 1'b0;
      copy_on_reg <= 1'b0;
      cstep_reg <= 5'h00;
      wc_cnt_reg <= 32'h0000_0000;
      page_reg <= 3'h0;
      wp_lat_reg <= 1'b0;
    end else if (bus_stop && state_reg == ee_pkg::ST_WDATA && got_data_reg && !busy_reg) begin
      busy_reg <= 1'b1;
      copy_on_reg <= 1'b1;
      cstep_reg <= 5'h00;
      wc_cnt_reg <= 32'h0000_0000;
      page_reg <= ptr_reg[6:4];
      wp_lat_reg <= pins_s2_reg[3];
    end else if (busy_reg) begin
      wc_cnt_reg <= wc_cnt_reg + 32'h0000_0001;
      if (cstep_reg == ee_pkg::COPY_LAST) begin
        copy_on_reg <= 1'b0;
      end else begin
        cstep_reg <= cstep_reg + 5'h01;
      end
      if (wc_cnt_reg == 32'(WRITE_CYCLES - 1)) begin
        busy_reg <= 1'b0;
      end
    end
  end
  // Array port: buffered data is read on the even step and stored on the odd.
  always_comb begin
    arr_if.we = busy_reg && copy_on_reg && cstep_reg[0] && valid_reg[cstep_reg[4:1]]
                && !prot_hit;
    arr_if.waddr = {page_reg, cstep_reg[4:1]};
    arr_if.wdata = pbuf_if.rdata;
    arr_if.raddr = ptr_reg;
  end

  // ==========================================================================
  // Memories
  ee_mem #(.AW(ee_pkg::ADDR_W)) u_array (.clk(clk), .bus(arr_if.mem));
  ee_mem #(.AW(ee_pkg::PAGE_W)) u_page_buf (.clk(clk), .bus(pbuf_if.mem));

  // ==========================================================================
  // Assertions
  sequence s_ctrl_done;
    byte_done && state_reg == ee_pkg::ST_CTRL;
  endsequence
  sequence s_wbyte_done;
    byte_done && state_reg == ee_pkg::ST_WDATA;
  endsequence
  property p_ack_match;
    @(posedge clk) disable iff (!reset_n) s_ctrl_done and ctrl_match |=> sda_oe;
  endproperty
  a_ack_match: assert property (p_ack_match) else $error("Control byte match not acked.");
  property p_nack_busy;
    @(posedge clk) disable iff (!reset_n) s_ctrl_done and busy_reg |=> !sda_oe;
  endproperty
  a_nack_busy: assert property (p_nack_busy) else $error("Control byte acked while busy.");
  property p_ptr_load;
    @(posedge clk) disable iff (!reset_n)
      byte_done && state_reg == ee_pkg::ST_ADDR |=> ptr_reg == $past(rx_reg[6:0]);
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("Word address not loaded.");
  property p_page_step;
    @(posedge clk) disable iff (!reset_n)
      s_wbyte_done |=> ptr_reg[6:4] == $past(ptr_reg[6:4])
                       && ptr_reg[3:0] == $past(ptr_reg[3:0]) + 4'h1;
  endproperty
  a_page_step: assert property (p_page_step) else $error("Page pointer step wrong.");
  // The cycle must start at the first step and target the page that was written.
  property p_stop_commit;
    @(posedge clk) disable iff (!reset_n)
      bus_stop && state_reg == ee_pkg::ST_WDATA && got_data_reg && !busy_reg
      |=> busy_reg && copy_on_reg && cstep_reg == 5'h00 && page_reg == $past(ptr_reg[6:4]);
  endproperty
  a_stop_commit: assert property (p_stop_commit) else $error("Stop did not start write.");
  // No array store may happen while data bytes are still arriving.
  property p_store_only_busy;
    @(posedge clk) disable iff (!reset_n)
      arr_if.we |-> $past(busy_reg) && state_reg != ee_pkg::ST_WDATA;
  endproperty
  a_store_only_busy: assert property (p_store_only_busy) else $error("Array store outside cycle.");
  property p_protect;
    @(posedge clk) disable iff (!reset_n)
      arr_if.we |-> !(wp_lat_reg && arr_if.waddr[ee_pkg::PROT_BIT]);
  endproperty
  a_protect: assert property (p_protect) else $error("Protected half was written.");
  property p_read_step;
    @(posedge clk) disable iff (!reset_n)
      ack_done && state_reg == ee_pkg::ST_RDATA && mack_reg
      |=> ptr_reg == $past(ptr_reg) + 7'h01 && tx_reg == $past(arr_if.rdata);
  endproperty
  a_read_step: assert property (p_read_step) else $error("Read pointer or byte wrong.");
  property p_release;
    @(posedge clk) disable iff (!reset_n)
      ack_done && state_reg == ee_pkg::ST_RDATA && !mack_reg |=> !sda_oe [*2];
  endproperty
  a_release: assert property (p_release) else $error("Data not released after nack.");
  property p_busy_hold;
    @(posedge clk) disable iff (!reset_n) $rose(busy_reg) |-> busy_reg [*8];
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("Write cycle ended too soon.");
endmodule : ee_page_eeprom

// ==== verification/ee_bus_master.sv ====
// Behavioural two-wire bus master that drives the memory slave.
module ee_bus_master (
  // Pacing clock.
  input wire logic clk,
  // Bus lines; sda_low pulls the open-drain data line.
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;

  // ======================================
  // Idle state
  // ======================================
  // The bus clock stands high outside frames and data is released.
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // ======================================
  // Bus conditions
  // ======================================
  // Half of the 80 ns bus period is five device clocks.
  task automatic half();
    repeat (5) @(negedge clk);
  endtask : half

  // Start or repeated Start: data falls while the clock is high.
  task automatic start();
    sda_low = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b1;
    half();
    scl = 1'b0;
  endtask : start

  // Stop: data rises while the clock is high, leaving the bus idle.
  task automatic stop();
    sda_low = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b0;
    half();
  endtask : stop

  // Sends a byte most significant bit first; returns the slave's acknowledge.
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low = ~b[i];
      half();
      scl = 1'b1;
      half();
      scl = 1'b0;
    end
    sda_low = 1'b0;
    half();
    scl = 1'b1;
    half();
    ack = ~sda;
    scl = 1'b0;
  endtask : put_byte

  // Receives a byte; a low ack_it withholds the acknowledge to end a read.
  // The data line is already released here by the previous byte's ack clock.
  task automatic get_byte(input logic ack_it, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      half();
      scl = 1'b1;
      half();
      b[i] = sda;
      scl = 1'b0;
    end
    sda_low = ack_it;
    half();
    scl = 1'b1;
    half();
    scl = 1'b0;
    sda_low = 1'b0;
  endtask : get_byte
endmodule : ee_bus_master

// ==== verification/testbench.sv ====
// Self-checking bench for the two-wire page-write memory slave.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // ======================================
  // Signals
  // ======================================
  // Write cycle long enough that the first poll still sees it busy.
  localparam int unsigned WCYC = 256;
  // Select straps of the slave.
  localparam logic [2:0] CS = 3'h5;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic wp = 1'b0;
  logic scl;
  logic m_low;
  logic sda_out;
  logic sda_oe;
  logic write_busy;
  // Pull-up data line, low while either party pulls it.
  wire logic sda = ~(m_low | (sda_oe & ~sda_out));
  int mismatches = 0;
  int check_count = 0;
  // Expected array contents.
  logic [7:0] mem_exp [128];

  always #4 clk = ~clk;

  ee_bus_master i_m (.clk(clk), .scl(scl), .sda_low(m_low), .sda(sda));
  ee_page_eeprom #(.WRITE_CYCLES(WCYC)) i_dut (.clk(clk), .reset_n(reset_n),
    .scl_pin(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .chip_select_bit0(CS[0]), .chip_select_bit1(CS[1]), .chip_select_bit2(CS[2]),
    .write_protect_pin(wp), .write_busy(write_busy));

  // ======================================
  // Helpers
  // ======================================
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    if (mismatches == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  function automatic logic [7:0] ctl(input logic [2:0] sel, input logic rw);
    return {ee_pkg::DEV_CODE, sel, rw};
  endfunction : ctl

  // Polls until acknowledged; the bound keeps a stuck cycle from hanging.
  task automatic poll_done();
    logic ack;
    int n;
    i_m.half();
    check("write_busy", {7'h00, write_busy}, 8'h01);
    for (n = 0; n < 20; n++) begin
      i_m.start();
      i_m.put_byte(ctl(CS, 1'b0), ack);
      i_m.stop();
      if (n == 0) check("busy poll ack", {7'h00, ack}, 8'h00);
      if (ack === 1'b1) break;
    end
    if (n == 20) begin
      mismatches++;
      stop_test();
    end
    check("idle after ack", {7'h00, write_busy}, 8'h00);
  endtask : poll_done

  // ======================================
  // Scenarios
  // ======================================
  // Page write of n bytes; the model wraps the in-page offset only.
  task automatic page_write(input logic [6:0] addr, input int n, input logic [7:0] base);
    logic ack;
    logic [6:0] a;
    a = addr;
    i_m.start();
    i_m.put_byte(ctl(CS, 1'b0), ack);
    check("write control ack", {7'h00, ack}, 8'h01);
    i_m.put_byte({1'b0, addr}, ack);
    check("address ack", {7'h00, ack}, 8'h01);
    for (int i = 0; i < n; i++) begin
      i_m.put_byte(base + 8'(i), ack);
      check("data ack", {7'h00, ack}, 8'h01);
      if (!(wp && a[6])) mem_exp[a] = base + 8'(i);
      a = {a[6:4], a[3:0] + 4'h1};
    end
    check("busy before stop", {7'h00, write_busy}, 8'h00);
    i_m.stop();
    poll_done();
  endtask : page_write

  // Reads n bytes, after setting the pointer when rnd is set.
  task automatic read_seq(input logic rnd, input logic [6:0] addr, input int n);
    logic ack;
    logic [7:0] d;
    logic [6:0] a;
    a = addr;
    if (rnd) begin
      i_m.start();
      i_m.put_byte(ctl(CS, 1'b0), ack);
      i_m.put_byte({1'b0, addr}, ack);
    end
    i_m.start();
    i_m.put_byte(ctl(CS, 1'b1), ack);
    check("read control ack", {7'h00, ack}, 8'h01);
    for (int i = 0; i < n; i++) begin
      i_m.get_byte(i < n - 1, d);
      check("read data", d, mem_exp[a]);
      a = a + 7'h01;
    end
    repeat (6) @(negedge clk);
    check("released after nack", {7'h00, sda_oe}, 8'h00);
    check("data drive level", {7'h00, sda_out}, 8'h00);
    i_m.stop();
  endtask : read_seq

  // Only the matching device code and select bits are acknowledged.
  task automatic sel_test();
    logic ack;
    for (int s = 0; s < 8; s++) begin
      i_m.start();
      i_m.put_byte(ctl(3'(s), 1'b0), ack);
      i_m.stop();
      check("select ack", {7'h00, ack}, {7'h00, 3'(s) == CS});
    end
    i_m.start();
    i_m.put_byte({4'h5, CS, 1'b0}, ack);
    i_m.stop();
    check("wrong code ack", {7'h00, ack}, 8'h00);
  endtask : sel_test

  // ======================================
  // Main sequence
  // ======================================
  initial begin
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    sel_test();
    page_write(7'h7e, 2, 8'h30);
    page_write(7'h00, 1, 8'h55);
    page_write(7'h1c, 18, 8'h80);
    read_seq(1'b1, 7'h1c, 3);
    read_seq(1'b0, 7'h1f, 1);
    read_seq(1'b1, 7'h7e, 3);
    wp = 1'b1;
    page_write(7'h7e, 1, 8'hee);
    page_write(7'h3f, 1, 8'h11);
    wp = 1'b0;
    read_seq(1'b1, 7'h3f, 1);
    read_seq(1'b1, 7'h7e, 1);
    stop_test();
  end
endmodule : testbench
